// >>> core/port_cfg_params.svh
// Constants for the port configuration block: offsets, modes, resets.
// Assumes inclusion by bare name from the package and the design file.
`ifndef PORT_CFG_PARAMS_SVH
`define PORT_CFG_PARAMS_SVH

// ****************************************************************
// Reset values
// ****************************************************************
`define MODE_RESET 5'h1f
`define CTL_RESET 8'hff
`define PENDING_RESET 8'h00
`define DATA_RESET 8'h00

// ****************************************************************
// Mode register layout and codes (low nibble, bit 4 = direction)
// ****************************************************************
`define MODE_WRITE_BIT 4
`define MODE_CMP 4'h8
`define MODE_PENDING 4'h9
`define MODE_EDGE 4'ha
`define MODE_WAKE_EN 4'hb
`define MODE_SCHMITT 4'hc
`define MODE_LEVEL 4'hd
`define MODE_PULLUP 4'he
`define MODE_DIR 4'hf

// ****************************************************************
// File register addresses of the port data registers
// ****************************************************************
`define FILE_PORT_A 5'h05
`define FILE_PORT_E 5'h09

// ****************************************************************
// Port indices and comparator register fields
// ****************************************************************
`define PORT_A 3'h0
`define PORT_B 3'h1
`define CMP_DISABLE_BIT 7
`define CMP_PIN_OFF_BIT 6
`define CMP_RESULT_BIT 0
`define CMP_OUT_PIN 0

`endif

// >>> core/port_cfg_pkg.sv
// Types shared by the port configuration block and its bench.
// Assumes port_cfg_params.svh is reachable on the include path.
`include "port_cfg_params.svh"

package port_cfg_pkg;

  // Per-port configuration word set held for each port
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] pullup_dis;
    logic [7:0] level;
    logic [7:0] schmitt_dis;
  } port_cfg_type;

  // One port control move from the CPU
  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic [7:0] w;
  } ctl_req_type;

  // Configuration register chosen by the mode register
  typedef enum logic [4:0] {
    SEL_NONE = 5'b00001,
    SEL_DIR = 5'b00010,
    SEL_PULLUP = 5'b00100,
    SEL_LEVEL = 5'b01000,
    SEL_SCHMITT = 5'b10000
  } cfg_sel_type;

endpackage : port_cfg_pkg

// >>> core/port_config_registers.sv
// Port configuration registers for five 8-bit ports, with port B
// wakeup edge capture and the comparator control register.
// Assumes a CPU core on the same clock issuing mode writes, port
// control moves and file register accesses as single-cycle strobes.
`include "port_cfg_params.svh"

// Notes on behaviour
// - pullup bit 1 disconnects, 0 connects; reset 1
// - level bit 1 TTL, 0 CMOS, Schmitt off
// - Schmitt bit 0 enables Schmitt; reset 1
// - wake enable bit 0 enables detection; reset 1
// - wake edge 0 rising, 1 falling; reset 1
// - mode 19h swaps W with pending flags
// - pending bit set by valid enabled edge
// - mode 08h swaps W with comparator register
// - comparator bit 7 clear enables comparator
// - comparator bit 6 clear drives port B pin0
// - comparator bit 0 is pin2 above pin1
// - power-up: control registers FFh, mode 1Fh
// - port data registers at file 05h to 09h
// - direction bit 1 input, 0 output; reset 1
// - mode bit 4 picks read or write move
// - mode value persists until rewritten
// - edge and enable always written from W
module port_config_registers #(
  parameter int NUM_PORTS = 5,
  parameter int PORT_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_wr,
  input wire logic [4:0] mode_wdata,
  output logic [4:0] mode_rdata,
  input port_cfg_pkg::ctl_req_type ctl_req,
  output logic w_load,
  output logic [7:0] w_rdata,
  input wire logic file_wr,
  input wire logic file_rd,
  input wire logic [4:0] file_addr,
  input wire logic [7:0] file_wdata,
  output logic file_hit,
  output logic [7:0] file_rdata,
  input wire logic [39:0] pin_in,
  output logic [39:0] pin_out,
  output logic [39:0] pin_oe_n,
  output logic [39:0] pullup_en,
  output logic [39:0] level_ttl,
  output logic [39:0] schmitt_en,
  input wire logic cmp_above,
  output logic cmp_enable,
  output logic [7:0] wake_enable_b,
  output logic [7:0] wake_pending_b,
  output logic wake_request
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The mode map and file addresses only cover five byte-wide ports
  if (NUM_PORTS != 5 || PORT_WIDTH != 8)
  begin : g_check
    $error("port_config_registers serves five 8-bit ports only");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Three stages; a change is taken once stages two and three agree,
  // so the filtered level lags a pin edge by three to four cycles.
  logic [39:0] pin_s1_q;
  logic [39:0] pin_s2_q;
  logic [39:0] pin_s3_q;
  logic [39:0] pin_q;
  logic [39:0] pin_d;
  logic cmp_s1_q;
  logic cmp_s2_q;
  logic cmp_s3_q;
  logic cmp_filt_q;
  logic cmp_filt_d;

  assign pin_d = (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
  assign cmp_filt_d = (cmp_s2_q == cmp_s3_q) ? cmp_s3_q : cmp_filt_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      pin_q <= '0;
    end
    else
    begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= pin_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      cmp_s3_q <= 1'b0;
      cmp_filt_q <= 1'b0;
    end
    else
    begin
      cmp_s1_q <= cmp_above;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      cmp_filt_q <= cmp_filt_d;
    end
  end

  // ****************************************************************
  // Mode register
  // ****************************************************************
  logic [4:0] mode_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= `MODE_RESET;
    else if (mode_wr)
      mode_q <= mode_wdata;
  end

  assign mode_rdata = mode_q;

  // ****************************************************************
  // Port control move decode
  // ****************************************************************
  logic [3:0] mode_low;
  logic mode_write;
  logic port_ok;
  logic port_is_b;
  logic port_is_a;
  port_cfg_pkg::cfg_sel_type cfg_sel;
  logic cfg_wr;
  logic cfg_rd;
  logic swap_cmp;
  logic swap_pnd;
  logic wr_edge;
  logic wr_wake_en;

  assign mode_low = mode_q[3:0];
  assign mode_write = mode_q[`MODE_WRITE_BIT];
  assign port_ok = ctl_req.valid && ctl_req.port <= 3'h4;
  assign port_is_b = ctl_req.valid && ctl_req.port == `PORT_B;
  assign port_is_a = ctl_req.port == `PORT_A;

  // Port A has no Schmitt register, so that code selects nothing
  assign cfg_sel =
    (mode_low == `MODE_DIR) ? port_cfg_pkg::SEL_DIR :
    (mode_low == `MODE_PULLUP) ? port_cfg_pkg::SEL_PULLUP :
    (mode_low == `MODE_LEVEL) ? port_cfg_pkg::SEL_LEVEL :
    (mode_low == `MODE_SCHMITT && !port_is_a) ?
      port_cfg_pkg::SEL_SCHMITT : port_cfg_pkg::SEL_NONE;

  assign cfg_wr = port_ok && mode_write &&
    cfg_sel != port_cfg_pkg::SEL_NONE;
  assign cfg_rd = port_ok && !mode_write &&
    cfg_sel != port_cfg_pkg::SEL_NONE;

  // Port B specials ignore the direction bit of the mode register
  assign swap_cmp = port_is_b && mode_low == `MODE_CMP;
  assign swap_pnd = port_is_b && mode_low == `MODE_PENDING;
  assign wr_edge = port_is_b && mode_low == `MODE_EDGE;
  assign wr_wake_en = port_is_b && mode_low == `MODE_WAKE_EN;

  // ****************************************************************
  // Per-port configuration and data registers
  // ****************************************************************
  port_cfg_pkg::port_cfg_type cfg_q [5];
  logic [7:0] data_q [5];
  logic [4:0] data_wr;
  logic [4:0] file_sel;

  for (genvar p = 0; p < 5; p++)
  begin : g_port
    logic sel_port;
    logic wr_here;

    assign sel_port = ctl_req.port == 3'(p);
    assign wr_here = cfg_wr && sel_port;
    assign file_sel[p] = file_addr == `FILE_PORT_A + 5'(p);
    assign data_wr[p] = file_wr && file_sel[p];

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        cfg_q[p] <= {4{`CTL_RESET}};
      else if (wr_here)
      begin
        unique case (cfg_sel)
          port_cfg_pkg::SEL_DIR:
            cfg_q[p].dir <= ctl_req.w;
          port_cfg_pkg::SEL_PULLUP:
            cfg_q[p].pullup_dis <= ctl_req.w;
          port_cfg_pkg::SEL_LEVEL:
            cfg_q[p].level <= ctl_req.w;
          port_cfg_pkg::SEL_SCHMITT:
            cfg_q[p].schmitt_dis <= ctl_req.w;
          default:
            cfg_q[p] <= cfg_q[p];
        endcase
      end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        data_q[p] <= `DATA_RESET;
      else if (data_wr[p])
        data_q[p] <= file_wdata;
    end

    // Pad controls; TTL sensing only counts while Schmitt is off
    assign pullup_en[p*8 +: 8] = ~cfg_q[p].pullup_dis;
    assign schmitt_en[p*8 +: 8] = ~cfg_q[p].schmitt_dis;
    assign level_ttl[p*8 +: 8] =
      cfg_q[p].level & cfg_q[p].schmitt_dis;
  end

  // ****************************************************************
  // Comparator register
  // ****************************************************************
  logic [7:1] cmp_ctrl_q;
  logic cmp_result;
  logic [7:0] cmp_view;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmp_ctrl_q <= 7'(`CTL_RESET >> 1);
    else if (swap_cmp)
      cmp_ctrl_q <= ctl_req.w[7:1];
  end

  assign cmp_enable = ~cmp_ctrl_q[`CMP_DISABLE_BIT];
  // A disabled comparator reports a low result
  assign cmp_result = cmp_enable & cmp_filt_q;
  assign cmp_view = {cmp_ctrl_q, cmp_result};

  // ****************************************************************
  // Port B wakeup edge capture
  // ****************************************************************
  logic [7:0] wake_dis_q;
  logic [7:0] wake_edge_q;
  logic [7:0] pend_q;
  logic [7:0] pend_d;
  logic [7:0] pb_prev_q;
  logic [7:0] pb_now;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] hit;

  assign pb_now = pin_q[15:8];
  assign rise = pb_now & ~pb_prev_q;
  assign fall = ~pb_now & pb_prev_q;
  assign hit = ((wake_edge_q & fall) | (~wake_edge_q & rise)) &
    ~wake_dis_q;
  // A fresh edge wins over a clear written in the same cycle
  assign pend_d = (swap_pnd ? ctl_req.w : pend_q) | hit;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_dis_q <= `CTL_RESET;
      wake_edge_q <= `CTL_RESET;
      pend_q <= `PENDING_RESET;
      pb_prev_q <= '0;
    end
    else
    begin
      if (wr_wake_en)
        wake_dis_q <= ctl_req.w;
      if (wr_edge)
        wake_edge_q <= ctl_req.w;
      pend_q <= pend_d;
      pb_prev_q <= pb_now;
    end
  end

  assign wake_enable_b = ~wake_dis_q;
  assign wake_pending_b = pend_q;
  assign wake_request = |pend_q;

  // ****************************************************************
  // Answer to the CPU's working register
  // ****************************************************************
  logic [7:0] cfg_rd_val;
  logic [7:0] w_d;
  logic w_load_q;
  logic [7:0] w_rdata_q;
  port_cfg_pkg::port_cfg_type cfg_cur;

  assign cfg_cur = port_ok ? cfg_q[ctl_req.port] : {4{`CTL_RESET}};
  assign cfg_rd_val =
    (cfg_sel == port_cfg_pkg::SEL_DIR) ? cfg_cur.dir :
    (cfg_sel == port_cfg_pkg::SEL_PULLUP) ? cfg_cur.pullup_dis :
    (cfg_sel == port_cfg_pkg::SEL_LEVEL) ? cfg_cur.level :
    cfg_cur.schmitt_dis;
  assign w_d = swap_cmp ? cmp_view : swap_pnd ? pend_q : cfg_rd_val;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_load_q <= 1'b0;
      w_rdata_q <= '0;
    end
    else
    begin
      w_load_q <= cfg_rd | swap_cmp | swap_pnd;
      if (cfg_rd | swap_cmp | swap_pnd)
        w_rdata_q <= w_d;
    end
  end

  assign w_load = w_load_q;
  assign w_rdata = w_rdata_q;

  // ****************************************************************
  // File register read port
  // ****************************************************************
  // Reads return the filtered pin levels; right after a change of
  // level or Schmitt mode the CPU must allow the filter to settle.
  logic hit_q;
  logic [7:0] file_rdata_q;
  logic [2:0] file_idx;
  logic file_any;

  assign file_any = |file_sel;
  assign file_idx = 3'(file_addr - `FILE_PORT_A);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hit_q <= 1'b0;
      file_rdata_q <= '0;
    end
    else
    begin
      hit_q <= file_rd && file_any;
      if (file_rd)
        file_rdata_q <= file_any ? pin_q[file_idx*8 +: 8] : 8'h00;
    end
  end

  assign file_hit = hit_q;
  assign file_rdata = file_rdata_q;

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic [39:0] out_q;
  logic [39:0] oe_n_q;
  logic [39:0] out_d;
  logic [39:0] oe_n_d;
  logic cmp_on_pin;

  assign cmp_on_pin = ~cmp_ctrl_q[`CMP_PIN_OFF_BIT];

  always_comb
  begin
    for (int p = 0; p < 5; p++)
    begin
      out_d[p*8 +: 8] = data_q[p];
      oe_n_d[p*8 +: 8] = cfg_q[p].dir;
    end
    if (cmp_on_pin)
    begin
      out_d[8 + `CMP_OUT_PIN] = cmp_result;
      oe_n_d[8 + `CMP_OUT_PIN] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= '0;
      oe_n_q <= '1;
    end
    else
    begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe_n = oe_n_q;

endmodule : port_config_registers

// >>> verification/port_config_registers_asserts.sv
// Checker for the port configuration block, bound to its top module.
// Assumes one clock and an asynchronous active-low reset.
module port_config_registers_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mode_wr,
  input wire logic [4:0] mode_wdata,
  input wire logic [4:0] mode_rdata,
  input port_cfg_pkg::ctl_req_type ctl_req,
  input wire logic w_load,
  input wire logic file_rd,
  input wire logic [4:0] file_addr,
  input wire logic file_hit,
  input wire logic [39:0] pullup_en,
  input wire logic [39:0] level_ttl,
  input wire logic [39:0] schmitt_en,
  input wire logic cmp_enable,
  input wire logic [7:0] wake_enable_b,
  input wire logic [7:0] wake_pending_b,
  input wire logic wake_request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // Port control moves, decoded with the mode in force at the edge
  // ****************************************************************
  sequence s_read_move;
    ctl_req.valid && !mode_rdata[4] && mode_rdata[3:2] == 2'b11
      && ctl_req.port <= 3'h4
      && !(ctl_req.port == 3'h0 && mode_rdata[1:0] == 2'b00);
  endsequence
  sequence s_swap_move;
    ctl_req.valid && ctl_req.port == 3'h1 && mode_rdata[3:1] == 3'b100;
  endsequence
  sequence s_write_move;
    ctl_req.valid && mode_rdata[4] && mode_rdata[3:2] == 2'b11;
  endsequence

  a_read_answers: assert property (s_read_move |=> w_load)
    else $error("read move gave no load");
  a_swap_answers: assert property (s_swap_move |=> w_load)
    else $error("swap move gave no load");
  a_write_silent: assert property (s_write_move |=> !w_load)
    else $error("write move loaded w");
  a_load_caused: assert property (w_load |-> $past(ctl_req.valid))
    else $error("load without a move");
  a_mode_takes: assert property (mode_wr |=> mode_rdata == $past(mode_wdata))
    else $error("mode write lost");
  a_cfg_stable: assert property (!ctl_req.valid |=>
    $stable(pullup_en) && $stable(cmp_enable) && $stable(wake_enable_b))
    else $error("config changed without a move");
  a_ttl_gated: assert property ((level_ttl & schmitt_en) == 40'h0)
    else $error("ttl sensing with schmitt on");
  a_port_a_plain: assert property (schmitt_en[7:0] == 8'h00)
    else $error("schmitt on port a");
  a_wake_summary: assert property (wake_request == |wake_pending_b)
    else $error("wake request mismatch");
  a_file_hit: assert property (file_hit ==
    $past(file_rd && file_addr >= 5'h05 && file_addr <= 5'h09))
    else $error("file hit wrong");
endmodule : port_config_registers_asserts

bind port_config_registers port_config_registers_asserts checker_i (
  .clk, .rst_n, .mode_wr, .mode_wdata, .mode_rdata, .ctl_req, .w_load,
  .file_rd, .file_addr, .file_hit, .pullup_en, .level_ttl, .schmitt_en,
  .cmp_enable, .wake_enable_b, .wake_pending_b, .wake_request
);

// >>> verification/cpu_core_model.sv
// CPU core model: mode writes, port control moves, file accesses.
// Assumes the bench calls its tasks from one clock domain.
module cpu_core_model (
  input wire logic clk,
  input wire logic w_load,
  input wire logic [7:0] w_rdata,
  output logic mode_wr,
  output logic [4:0] mode_wdata,
  output port_cfg_pkg::ctl_req_type ctl_req,
  output logic file_wr,
  output logic file_rd,
  output logic [4:0] file_addr,
  output logic [7:0] file_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] w_q = 8'h00;
  int loads = 0;

  initial
  begin
    mode_wr = 1'b0;
    mode_wdata = 5'h00;
    ctl_req = '0;
    file_wr = 1'b0;
    file_rd = 1'b0;
    file_addr = 5'h00;
    file_wdata = 8'h00;
  end

  // ****************************************************************
  // Strobes rise after an edge, drop after the taking edge
  // ****************************************************************
  task automatic set_mode(input logic [4:0] m);
    @(posedge clk);
    #1 mode_wr = 1'b1;
    mode_wdata = m;
    @(posedge clk);
    #1 mode_wr = 1'b0;
    mode_wdata = ~m;
  endtask : set_mode

  // Released data is inverted so a stale value is never mistaken
  task automatic move(input logic [2:0] p, input logic [7:0] w);
    @(posedge clk);
    #1 ctl_req = '{1'b1, p, w};
    @(posedge clk);
    #1 ctl_req = '{1'b0, p, ~w};
    if (w_load === 1'b1)
    begin
      w_q = w_rdata;
      loads++;
    end
    else
      w_q = w;
  endtask : move

  task automatic file_op(input logic wr, input logic [4:0] a,
    input logic [7:0] d);
    @(posedge clk);
    #1 file_wr = wr;
    file_rd = !wr;
    file_addr = a;
    file_wdata = d;
    @(posedge clk);
    #1 file_wr = 1'b0;
    file_rd = 1'b0;
    file_wdata = ~d;
  endtask : file_op
endmodule : cpu_core_model

// >>> verification/port_config_registers_tb.sv
// Self-checking bench for the port configuration block.
// Assumes the checker binds itself and the CPU model drives requests.
module port_config_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n;
  logic cmp_above;
  logic [39:0] pin_in;
  logic mode_wr, w_load, file_wr, file_rd, file_hit, cmp_enable;
  logic wake_request;
  logic [4:0] mode_wdata, mode_rdata, file_addr;
  logic [7:0] w_rdata, file_wdata, file_rdata, wake_enable_b;
  logic [7:0] wake_pending_b;
  logic [39:0] pin_out, pin_oe_n, pullup_en, level_ttl, schmitt_en;
  port_cfg_pkg::ctl_req_type ctl_req;
  logic [3:0] codes [4] = '{4'hf, 4'he, 4'hd, 4'hc};
  int num_errors = 0;
  int checked = 0;

  always #5 clk = ~clk;

  port_config_registers dut (
    .clk(clk), .rst_n(rst_n), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .mode_rdata(mode_rdata), .ctl_req(ctl_req),
    .w_load(w_load), .w_rdata(w_rdata), .file_wr(file_wr),
    .file_rd(file_rd), .file_addr(file_addr), .file_wdata(file_wdata),
    .file_hit(file_hit), .file_rdata(file_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .level_ttl(level_ttl), .schmitt_en(schmitt_en),
    .cmp_above(cmp_above), .cmp_enable(cmp_enable),
    .wake_enable_b(wake_enable_b), .wake_pending_b(wake_pending_b),
    .wake_request(wake_request)
  );
  cpu_core_model cpu (
    .clk(clk), .w_load(w_load), .w_rdata(w_rdata), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .ctl_req(ctl_req), .file_wr(file_wr),
    .file_rd(file_rd), .file_addr(file_addr), .file_wdata(file_wdata)
  );

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic check(input logic [39:0] got, exp, input string what);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  function automatic logic [7:0] val(input logic [3:0] c, input int p);
    return {c, 1'b0, 3'(p)};
  endfunction : val

  task automatic wait_pending(input logic [7:0] exp);
    int n;
    n = 0;
    while (wake_pending_b !== exp && n < 20)
    begin
      tick(1);
      n++;
    end
    if (wake_pending_b !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: pending wait timed out", $time);
      end_sim();
    end
  endtask : wait_pending

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    rst_n = 1'b0;
    tick(4);
    rst_n = 1'b1;
    check(mode_rdata, 40'h1f, "mode");
    check(pullup_en, 40'h0, "pullup");
    check(level_ttl, '1, "level");
    check(schmitt_en, 40'h0, "schmitt");
    check(pin_oe_n, '1, "dir");
    check(wake_enable_b, 40'h0, "wake en");
    check({cmp_enable, wake_pending_b}, 40'h0, "cmp pend");
    $display("test reset done");
  endtask : test_reset

  task automatic test_cfg();
    foreach (codes[i])
    begin
      cpu.set_mode({1'b1, codes[i]});
      for (int p = 0; p < 5; p++)
        cpu.move(3'(p), val(codes[i], p));
    end
    foreach (codes[i])
    begin
      cpu.set_mode({1'b0, codes[i]});
      for (int p = 0; p < 5; p++)
      begin
        cpu.move(3'(p), 8'h00);
        check(cpu.w_q, (i == 3 && p == 0) ? 8'h00 : val(codes[i], p),
          "readback");
      end
    end
    for (int p = 0; p < 5; p++)
    begin
      check(pin_oe_n[8*p+:8], val(4'hf, p), "dir");
      check(pullup_en[8*p+:8], 8'(~val(4'he, p)), "pullup");
      check(schmitt_en[8*p+:8], p ? 8'(~val(4'hc, p)) : 8'h00, "st");
      check(level_ttl[8*p+:8], val(4'hd, p) & (p ? val(4'hc, p) : 8'hff),
        "level");
    end
    $display("test cfg done");
  endtask : test_cfg

  task automatic test_refused();
    logic [39:0] pu, st;
    int n;
    pu = pullup_en;
    st = schmitt_en;
    n = cpu.loads;
    cpu.set_mode(5'h1c);
    cpu.move(3'h0, 8'h00);
    cpu.set_mode(5'h1e);
    cpu.move(3'h5, 8'h00);
    cpu.move(3'h7, 8'h00);
    cpu.set_mode(5'h12);
    cpu.move(3'h1, 8'h00);
    cpu.set_mode(5'h0c);
    cpu.move(3'h0, 8'h00);
    check({pullup_en ^ pu} | {schmitt_en ^ st}, 40'h0, "changed");
    check(40'(cpu.loads - n), 40'h0, "loads");
    $display("test refused done");
  endtask : test_refused

  task automatic test_wake();
    cpu.set_mode(5'h0a);
    cpu.move(3'h1, 8'h10);
    cpu.set_mode(5'h0b);
    cpu.move(3'h1, 8'he7);
    check(wake_enable_b, 40'h18, "wake en");
    pin_in[13:11] = 3'b111;
    wait_pending(8'h08);
    tick(6);
    check(wake_pending_b, 40'h08, "rising only");
    pin_in[12] = 1'b0;
    wait_pending(8'h18);
    check(wake_request, 40'h1, "wake request");
    cpu.set_mode(5'h19);
    cpu.move(3'h1, 8'h00);
    check(cpu.w_q, 40'h18, "swap out");
    check(wake_pending_b, 40'h00, "swap in");
    $display("test wake done");
  endtask : test_wake

  task automatic test_cmp();
    cpu.set_mode(5'h1f);
    cpu.move(3'h1, 8'hfe);
    cpu.set_mode(5'h08);
    cpu.move(3'h1, 8'h3e);
    check(cpu.w_q, 40'hfe, "cmp first");
    check(cmp_enable, 40'h1, "cmp on");
    cmp_above = 1'b1;
    tick(6);
    check(pin_out[8], 40'h1, "cmp pin hi");
    cpu.set_mode(5'h18);
    cpu.move(3'h1, 8'h3e);
    check(cpu.w_q, 40'h3f, "cmp above");
    cmp_above = 1'b0;
    tick(6);
    check(pin_out[8], 40'h0, "cmp pin lo");
    cpu.move(3'h1, 8'hff);
    check(cpu.w_q, 40'h3e, "cmp below");
    check(cmp_enable, 40'h0, "cmp off");
    $display("test cmp done");
  endtask : test_cmp

  task automatic test_file();
    cpu.set_mode(5'h1f);
    cpu.move(3'h1, 8'h00);
    cpu.file_op(1'b1, 5'h06, 8'h55);
    tick(2);
    check(pin_out[15:8], 40'h55, "data out");
    pin_in = 40'h5a_c3_96_3c_a5;
    tick(5);
    for (int a = 5; a < 10; a++)
    begin
      cpu.file_op(1'b0, 5'(a), 8'h00);
      check(file_hit, 40'h1, "hit");
      check(file_rdata, 40'(pin_in[8*(a-5)+:8]), "read");
    end
    cpu.file_op(1'b0, 5'h0a, 8'h00);
    check({file_hit, file_rdata}, 40'h0, "unmapped");
    $display("test file done");
  endtask : test_file

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    cmp_above = 1'b0;
    pin_in = 40'h0;
    test_reset();
    test_cfg();
    test_refused();
    test_wake();
    test_cmp();
    test_file();
    test_reset();
    end_sim();
  end

  initial
  begin
    #200000;
    num_errors++;
    $display("mismatch at %0t: run timed out", $time);
    end_sim();
  end
endmodule : port_config_registers_tb
